// >>> rtl/usa_alu_regs.svh
`ifndef USA_ALU_REGS_SVH
`define USA_ALU_REGS_SVH

// Register indices that make some operand combinations unpredictable
`define USA_IDX_SP       4'hD
`define USA_IDX_PC       4'hF
// A first operand field of all ones selects the form without addition
`define USA_IDX_NO_ADD   4'hF

// Rotate amount is the two-bit field followed by these three zero bits
`define USA_ROT_ZEROS    3'h0

// Unsigned halfword sum limit for the exchange add lane
`define USA_CARRY_LIMIT  17'h1_0000

// Lane flag patterns
`define USA_GE_PAIR_SET  2'h3
`define USA_GE_PAIR_CLR  2'h0

// Reset values
`define USA_RESULT_RST   32'h0000_0000
`define USA_GE_RST       4'h0
`define USA_Q_RST        1'h0
`define USA_IDX_RST      4'h0

`endif

// >>> rtl/usa_pkg.sv
package usa_pkg;

    typedef enum logic [2:0] {
        USA_OP_DUAL_HALF_UNSIGNED_SATURATE = 3'h0,
        USA_OP_EXCHANGE_SUB_ADD            = 3'h1,
        USA_OP_LEGACY_EXCHANGE_SUB_ADD     = 3'h2,
        USA_OP_DUAL_HALF_SUBTRACT          = 3'h3,
        USA_OP_QUAD_BYTE_SUBTRACT          = 3'h4,
        USA_OP_ROTATE_EXTEND_BYTE_ADD      = 3'h5,
        USA_OP_ROTATE_EXTEND_BYTE          = 3'h6
    } usa_op_type;

    typedef struct packed {
        logic        valid;
        logic        cond_pass;
        usa_op_type  op;
        logic [31:0] first_operand;
        logic [31:0] second_operand;
        logic [1:0]  rotate;
        logic [3:0]  saturation_width;
        logic [3:0]  dest_reg;
        logic [3:0]  first_operand_reg;
        logic [3:0]  second_operand_reg;
    } usa_req_type;

endpackage

// >>> rtl/usa_alu.sv
`timescale 1ns/1ps
`include "usa_alu_regs.svh"

module usa_alu (
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire usa_pkg::usa_req_type req,
    output logic [31:0]               result_r,
    output logic [3:0]                result_dest_r,
    output logic                      result_valid_r,
    output logic                      unpredictable_r,
    output logic [3:0]                lane_ge_flags_r,
    output logic                      sticky_saturation_flag_r
);

    logic [31:0] result_nxt;
    logic [3:0]  ge_nxt;
    logic        ge_write;
    logic        sat_hit;
    logic        unpred_nxt;
    logic        commit;
    logic [16:0] sat_lo;
    logic [16:0] sat_hi;
    logic [16:0] xsum;
    logic [16:0] xdiff;
    logic [16:0] hdiff_lo;
    logic [16:0] hdiff_hi;
    logic [31:0] bdiff;
    logic [3:0]  bge;
    logic [4:0]  rot_amt;
    logic [63:0] rot_dbl;
    logic [31:0] rotated;
    logic [31:0] ext_byte;
    logic [31:0] add_base;

    // Returns {clamped, value}; the input is a signed halfword
    function automatic logic [16:0] clamp_half(input logic [15:0] x, input logic [3:0] w);
        logic [15:0] maxv;
        maxv = (16'h0001 << w) - 16'h0001;
        if (x[15])
            clamp_half = {1'b1, 16'h0000};
        else if (x > maxv)
            clamp_half = {1'b1, maxv};
        else
            clamp_half = {1'b0, x};
    endfunction

    function automatic logic bad_idx(input logic [3:0] idx);
        bad_idx = (idx == `USA_IDX_SP) || (idx == `USA_IDX_PC);
    endfunction

    assign commit = req.valid && req.cond_pass;

    assign sat_lo = clamp_half(req.first_operand[15:0], req.saturation_width);
    assign sat_hi = clamp_half(req.first_operand[31:16], req.saturation_width);

    assign xsum  = {1'b0, req.first_operand[15:0]} + {1'b0, req.second_operand[31:16]};
    assign xdiff = {1'b0, req.first_operand[31:16]} - {1'b0, req.second_operand[15:0]};

    assign hdiff_lo = {1'b0, req.first_operand[15:0]}
                      - {1'b0, req.second_operand[15:0]};
    assign hdiff_hi = {1'b0, req.first_operand[31:16]}
                      - {1'b0, req.second_operand[31:16]};

    // Ninth bit of each byte difference is the borrow
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_byte
            logic [8:0] d;
            assign d = {1'b0, req.first_operand[8*gi +: 8]}
                       - {1'b0, req.second_operand[8*gi +: 8]};
            assign bdiff[8*gi +: 8] = d[7:0];
            assign bge[gi] = ~d[8];
        end
    endgenerate

    // Doubling the word turns the right rotate into a plain shift
    assign rot_amt  = {req.rotate, `USA_ROT_ZEROS};
    assign rot_dbl  = {req.second_operand, req.second_operand} >> rot_amt;
    assign rotated  = rot_dbl[31:0];
    assign ext_byte = {24'h000000, rotated[7:0]};
    assign add_base = (req.op == usa_pkg::USA_OP_ROTATE_EXTEND_BYTE
                       || req.first_operand_reg == `USA_IDX_NO_ADD)
                      ? 32'h0000_0000 : req.first_operand;

    always_comb
    begin
        result_nxt = `USA_RESULT_RST;
        ge_nxt     = lane_ge_flags_r;
        ge_write   = 1'b0;
        sat_hit    = 1'b0;
        unpred_nxt = 1'b0;
        unique case (req.op)
            usa_pkg::USA_OP_DUAL_HALF_UNSIGNED_SATURATE:
            begin
                result_nxt = {sat_hi[15:0], sat_lo[15:0]};
                sat_hit    = sat_lo[16] || sat_hi[16];
                unpred_nxt = bad_idx(req.dest_reg) || bad_idx(req.first_operand_reg);
            end
            usa_pkg::USA_OP_EXCHANGE_SUB_ADD,
            usa_pkg::USA_OP_LEGACY_EXCHANGE_SUB_ADD:
            begin
                result_nxt  = {xdiff[15:0], xsum[15:0]};
                ge_write    = 1'b1;
                ge_nxt[1:0] = (xsum >= `USA_CARRY_LIMIT) ? `USA_GE_PAIR_SET
                                                           : `USA_GE_PAIR_CLR;
                ge_nxt[3:2] = xdiff[16] ? `USA_GE_PAIR_CLR : `USA_GE_PAIR_SET;
                unpred_nxt  = bad_idx(req.dest_reg) || bad_idx(req.first_operand_reg)
                              || bad_idx(req.second_operand_reg);
            end
            usa_pkg::USA_OP_DUAL_HALF_SUBTRACT:
            begin
                result_nxt  = {hdiff_hi[15:0], hdiff_lo[15:0]};
                ge_write    = 1'b1;
                ge_nxt[1:0] = hdiff_lo[16] ? `USA_GE_PAIR_CLR : `USA_GE_PAIR_SET;
                ge_nxt[3:2] = hdiff_hi[16] ? `USA_GE_PAIR_CLR : `USA_GE_PAIR_SET;
                unpred_nxt  = bad_idx(req.dest_reg) || bad_idx(req.first_operand_reg)
                              || bad_idx(req.second_operand_reg);
            end
            usa_pkg::USA_OP_QUAD_BYTE_SUBTRACT:
            begin
                result_nxt = bdiff;
                ge_write   = 1'b1;
                ge_nxt     = bge;
                unpred_nxt = bad_idx(req.dest_reg) || bad_idx(req.first_operand_reg)
                             || bad_idx(req.second_operand_reg);
            end
            usa_pkg::USA_OP_ROTATE_EXTEND_BYTE_ADD:
            begin
                result_nxt = add_base + ext_byte;
                unpred_nxt = bad_idx(req.dest_reg) || bad_idx(req.second_operand_reg)
                             || (req.first_operand_reg == `USA_IDX_SP
                                 && req.first_operand_reg != `USA_IDX_NO_ADD);
            end
            usa_pkg::USA_OP_ROTATE_EXTEND_BYTE:
            begin
                result_nxt = ext_byte;
                unpred_nxt = bad_idx(req.dest_reg) || bad_idx(req.second_operand_reg);
            end
            default:
            begin
                // Unused opcode: report it and leave flags alone
                unpred_nxt = 1'b1;
            end
        endcase
    end

    // Result and destination hold until the next committed instruction
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            result_r      <= `USA_RESULT_RST;
            result_dest_r <= `USA_IDX_RST;
        end
        else if (commit)
        begin
            result_r      <= result_nxt;
            result_dest_r <= req.dest_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            result_valid_r  <= 1'b0;
            unpredictable_r <= 1'b0;
        end
        else
        begin
            result_valid_r  <= commit;
            unpredictable_r <= commit && unpred_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            lane_ge_flags_r <= `USA_GE_RST;
        else if (commit && ge_write)
            lane_ge_flags_r <= ge_nxt;
    end

    // Sticky: only a saturating instruction can touch it, and only to set
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            sticky_saturation_flag_r <= `USA_Q_RST;
        else if (commit && sat_hit)
            sticky_saturation_flag_r <= 1'b1;
    end

    sequence s_issue(usa_pkg::usa_op_type o);
        req.valid && req.cond_pass && req.op == o;
    endsequence

    sequence s_skip;
        !(req.valid && req.cond_pass);
    endsequence

    chk_sat_range: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_issue(usa_pkg::USA_OP_DUAL_HALF_UNSIGNED_SATURATE) |=>
            result_r[15:0] <= ((16'h0001 << $past(req.saturation_width)) - 16'h0001)
            && result_r[31:16] <= ((16'h0001 << $past(req.saturation_width)) - 16'h0001))
        else $error("saturate result outside range");

    chk_sat_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_issue(usa_pkg::USA_OP_DUAL_HALF_UNSIGNED_SATURATE)
        ##0 (req.first_operand[15] || req.first_operand[31]) |=> sticky_saturation_flag_r)
        else $error("negative half did not set sticky flag");

    chk_sticky_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        sticky_saturation_flag_r |=> sticky_saturation_flag_r)
        else $error("sticky flag cleared");

    chk_xsa_result: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_issue(usa_pkg::USA_OP_EXCHANGE_SUB_ADD) |=>
            result_r[15:0] == 16'($past(req.first_operand[15:0])
                                  + $past(req.second_operand[31:16]))
            && result_r[31:16] == 16'($past(req.first_operand[31:16])
                                      - $past(req.second_operand[15:0])))
        else $error("exchange result wrong");

    chk_xsa_flags: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_issue(usa_pkg::USA_OP_EXCHANGE_SUB_ADD) |=>
            lane_ge_flags_r[1:0] == {2{17'($past(req.first_operand[15:0]))
                + 17'($past(req.second_operand[31:16])) >= `USA_CARRY_LIMIT}}
            && lane_ge_flags_r[3:2] == {2{$past(req.first_operand[31:16])
                                          >= $past(req.second_operand[15:0])}})
        else $error("exchange lane flags wrong");

    chk_sub_unpred: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_issue(usa_pkg::USA_OP_QUAD_BYTE_SUBTRACT) ##0 req.dest_reg == `USA_IDX_PC
        |=> unpredictable_r && result_valid_r)
        else $error("unpredictable not reported");

    chk_h16_result: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_issue(usa_pkg::USA_OP_DUAL_HALF_SUBTRACT) |=>
            result_r == {16'($past(req.first_operand[31:16]) - $past(req.second_operand[31:16])),
                         16'($past(req.first_operand[15:0]) - $past(req.second_operand[15:0]))})
        else $error("halfword subtract result wrong");

    chk_h16_flags: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_issue(usa_pkg::USA_OP_DUAL_HALF_SUBTRACT) |=>
            lane_ge_flags_r[1:0] == {2{$past(req.first_operand[15:0])
                                        >= $past(req.second_operand[15:0])}}
            && lane_ge_flags_r[3:2] == {2{$past(req.first_operand[31:16])
                                          >= $past(req.second_operand[31:16])}})
        else $error("halfword lane flags wrong");

    chk_b8_result: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_issue(usa_pkg::USA_OP_QUAD_BYTE_SUBTRACT) |=>
            result_r[31:24] == 8'($past(req.first_operand[31:24])
                                  - $past(req.second_operand[31:24]))
            && result_r[7:0] == 8'($past(req.first_operand[7:0]) - $past(req.second_operand[7:0])))
        else $error("byte subtract result wrong");

    chk_b8_flags: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_issue(usa_pkg::USA_OP_QUAD_BYTE_SUBTRACT) |=>
            lane_ge_flags_r[3] == ($past(req.first_operand[31:24])
                                   >= $past(req.second_operand[31:24]))
            && lane_ge_flags_r[2] == ($past(req.first_operand[23:16])
                                      >= $past(req.second_operand[23:16]))
            && lane_ge_flags_r[0] == ($past(req.first_operand[7:0])
                                      >= $past(req.second_operand[7:0])))
        else $error("byte lane flags wrong");

    chk_b8_lane1: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_issue(usa_pkg::USA_OP_QUAD_BYTE_SUBTRACT) |=>
            lane_ge_flags_r[1] == ($past(req.first_operand[15:8])
                                   >= $past(req.second_operand[15:8])))
        else $error("byte lane 1 flag wrong");

    chk_ext_add: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_issue(usa_pkg::USA_OP_ROTATE_EXTEND_BYTE_ADD) ##0 req.rotate == 2'h0
        ##0 req.first_operand_reg != `USA_IDX_NO_ADD |=>
            result_r == $past(req.first_operand) + {24'h000000, $past(req.second_operand[7:0])})
        else $error("extend add result wrong");

    chk_rot_amount: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_issue(usa_pkg::USA_OP_ROTATE_EXTEND_BYTE) ##0 req.rotate == 2'h3 |=>
            result_r == {24'h000000, $past(req.second_operand[31:24])})
        else $error("rotate by 24 wrong");

    chk_no_add: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_issue(usa_pkg::USA_OP_ROTATE_EXTEND_BYTE_ADD)
        ##0 req.first_operand_reg == `USA_IDX_NO_ADD |=> result_r[31:8] == 24'h000000)
        else $error("alias form added first operand");

    chk_ext_unpred: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_issue(usa_pkg::USA_OP_ROTATE_EXTEND_BYTE_ADD) ##0 req.first_operand_reg == `USA_IDX_SP
        |=> unpredictable_r)
        else $error("first operand 13 not reported");

    chk_cond_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_skip |=> !result_valid_r && $stable(result_r) && $stable(lane_ge_flags_r)
                   && $stable(sticky_saturation_flag_r))
        else $error("state changed on failed condition");

endmodule // usa_alu

// >>> tb/usa_issue_model.sv
`timescale 1ns/1ps

module usa_issue_model (
    input  wire logic            ref_clk,
    input  wire logic            nrst,
    output usa_pkg::usa_req_type req
);
    initial req = '0;

    // One instruction a slot, launched 1 ns after the edge; nothing leaves while in reset
    task automatic issue(input usa_pkg::usa_req_type r);
        usa_pkg::usa_req_type t;
        @(posedge ref_clk);
        #1;
        t = r;
        t.valid = r.valid & nrst;
        req = t;
    endtask

    // Idle slots clear valid and scramble every other field so a stale word cannot pass for a held request
    task automatic idle();
        usa_pkg::usa_req_type t;
        @(posedge ref_clk);
        #1;
        t = ~req;
        t.valid = 1'h0;
        req = t;
    endtask
endmodule // usa_issue_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    typedef struct packed {
        logic [2:0]  op;
        logic [31:0] a;
        logic [31:0] b;
        logic [1:0]  rot;
        logic [3:0]  w;
        logic [3:0]  dreg;
        logic [3:0]  nreg;
        logic [3:0]  mreg;
        logic [31:0] res;
        logic [3:0]  ge;
        logic        q;
        logic        unp;
    } usa_row_type;

    logic                 ref_clk;
    logic                 nrst;
    usa_pkg::usa_req_type req;
    logic [31:0]          result_r;
    logic [3:0]           result_dest_r;
    logic                 result_valid_r;
    logic                 unpredictable_r;
    logic [3:0]           lane_ge_flags_r;
    logic                 sticky_saturation_flag_r;
    int                   n_fail;
    int                   total_checks;
    int                   cycles;
    usa_row_type          rows [21];
    usa_row_type          hr;

    usa_issue_model u_issue (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .req     (req)
    );

    usa_alu DUT (
        .ref_clk                  (ref_clk),
        .nrst                     (nrst),
        .req                      (req),
        .result_r                 (result_r),
        .result_dest_r            (result_dest_r),
        .result_valid_r           (result_valid_r),
        .unpredictable_r          (unpredictable_r),
        .lane_ge_flags_r          (lane_ge_flags_r),
        .sticky_saturation_flag_r (sticky_saturation_flag_r)
    );

    initial
    begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
        cmp32({28'h0, got}, {28'h0, exp});
    endtask

    task automatic cmp1(input logic got, input logic exp);
        cmp32({31'h0, got}, {31'h0, exp});
    endtask

    task automatic send(input usa_row_type rw, input logic vld, input logic cp);
        u_issue.issue('{vld, cp, usa_pkg::usa_op_type'(rw.op), rw.a, rw.b, rw.rot, rw.w,
                        rw.dreg, rw.nreg, rw.mreg});
    endtask

    // Outputs of the request taken at the edge just passed
    task automatic chk_row(input usa_row_type rw);
        cmp32(result_r, rw.res);
        cmp4(result_dest_r, rw.dreg);
        cmp1(result_valid_r, 1'h1);
        cmp1(unpredictable_r, rw.unp);
        cmp4(lane_ge_flags_r, rw.ge);
        cmp1(sticky_saturation_flag_r, rw.q);
    endtask

    task automatic chk_quiet(input logic [31:0] res, input logic [3:0] ge);
        cmp1(result_valid_r, 1'h0);
        cmp32(result_r, res);
        cmp4(lane_ge_flags_r, ge);
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 400)
        begin
            n_fail++;
            final_report();
        end
    end

    initial
    begin
        nrst = 1'h0;
        n_fail = 0;
        total_checks = 0;
        cycles = 0;
        // op, a, b, rot, w, dest, first, second, result, ge, sticky, unpredictable
        rows = '{
            '{3'h3, 32'h00050001, 32'h00030002, 2'h0, 4'h0, 4'h1, 4'h2, 4'h3,
              32'h0002FFFF, 4'hC, 1'h0, 1'h0},
            '{3'h1, 32'h0001FFFF, 32'h00020003, 2'h0, 4'h0, 4'h1, 4'h2, 4'h3,
              32'hFFFE0001, 4'h3, 1'h0, 1'h0},
            '{3'h2, 32'h80000010, 32'h00200005, 2'h0, 4'h0, 4'h1, 4'h2, 4'h3,
              32'h7FFB0030, 4'hC, 1'h0, 1'h0},
            '{3'h4, 32'h10FF0005, 32'h20010500, 2'h0, 4'h0, 4'h1, 4'h2, 4'h3,
              32'hF0FEFB05, 4'h5, 1'h0, 1'h0},
            '{3'h4, 32'h00000500, 32'h01010001, 2'h0, 4'h0, 4'h1, 4'h2, 4'h3,
              32'hFFFF05FF, 4'h2, 1'h0, 1'h0},
            '{3'h5, 32'h00000100, 32'h44332211, 2'h0, 4'h0, 4'h1, 4'h2, 4'h3,
              32'h00000111, 4'h2, 1'h0, 1'h0},
            '{3'h5, 32'h00000100, 32'h44332211, 2'h1, 4'h0, 4'h1, 4'h2, 4'h3,
              32'h00000122, 4'h2, 1'h0, 1'h0},
            '{3'h5, 32'h00000100, 32'h44332211, 2'h2, 4'h0, 4'h1, 4'h2, 4'h3,
              32'h00000133, 4'h2, 1'h0, 1'h0},
            '{3'h5, 32'h00000100, 32'h44332211, 2'h3, 4'h0, 4'h1, 4'h2, 4'h3,
              32'h00000144, 4'h2, 1'h0, 1'h0},
            '{3'h5, 32'hFFFFFFFF, 32'h000000FF, 2'h0, 4'h0, 4'h1, 4'h2, 4'h3,
              32'h000000FE, 4'h2, 1'h0, 1'h0},
            '{3'h5, 32'h12345678, 32'h44332281, 2'h1, 4'h0, 4'h1, 4'hF, 4'h3,
              32'h00000022, 4'h2, 1'h0, 1'h0},
            '{3'h6, 32'h12345678, 32'h44332211, 2'h3, 4'h0, 4'h1, 4'h2, 4'h3,
              32'h00000044, 4'h2, 1'h0, 1'h0},
            '{3'h0, 32'h00030005, 32'h00000000, 2'h0, 4'h4, 4'h1, 4'h2, 4'h3,
              32'h00030005, 4'h2, 1'h0, 1'h0},
            '{3'h0, 32'h7FFF0000, 32'h00000000, 2'h0, 4'hF, 4'h1, 4'h2, 4'h3,
              32'h7FFF0000, 4'h2, 1'h0, 1'h0},
            '{3'h0, 32'h0010000F, 32'h00000000, 2'h0, 4'h4, 4'h1, 4'h2, 4'h3,
              32'h000F000F, 4'h2, 1'h1, 1'h0},
            '{3'h0, 32'hFFFF0020, 32'h00000000, 2'h0, 4'h4, 4'h1, 4'h2, 4'h3,
              32'h0000000F, 4'h2, 1'h1, 1'h0},
            '{3'h0, 32'h00000001, 32'h00000000, 2'h0, 4'h0, 4'h1, 4'h2, 4'h3,
              32'h00000000, 4'h2, 1'h1, 1'h0},
            '{3'h3, 32'h00000000, 32'h00000001, 2'h0, 4'h0, 4'hD, 4'h2, 4'h3,
              32'h0000FFFF, 4'hC, 1'h1, 1'h1},
            '{3'h1, 32'h00000000, 32'h00000000, 2'h0, 4'h0, 4'h1, 4'hF, 4'h3,
              32'h00000000, 4'hC, 1'h1, 1'h1},
            '{3'h5, 32'h00000001, 32'h00000002, 2'h0, 4'h0, 4'h1, 4'hD, 4'h3,
              32'h00000003, 4'hC, 1'h1, 1'h1},
            '{3'h4, 32'hFFFFFFFF, 32'hFFFFFFFF, 2'h0, 4'h0, 4'hF, 4'h2, 4'h3,
              32'h00000000, 4'hF, 1'h1, 1'h1}
        };
        repeat (6) @(posedge ref_clk);
        #1;
        nrst = 1'h1;
        chk_quiet(32'h0, 4'h0);
        cmp1(sticky_saturation_flag_r, 1'h0);
        // Back to back: each slot launches one request and checks the one before
        for (int i = 0; i < 21; i++)
        begin
            send(rows[i], 1'h1, 1'h1);
            if (i > 0)
                chk_row(rows[i - 1]);
        end
        u_issue.idle();
        chk_row(rows[20]);
        send(rows[0], 1'h1, 1'h0);
        u_issue.idle();
        chk_quiet(32'h0, 4'hF);
        send(rows[3], 1'h0, 1'h1);
        u_issue.idle();
        chk_quiet(32'h0, 4'hF);
        hr = '{3'h7, 32'h1, 32'h2, 2'h0, 4'h0, 4'h1, 4'h2, 4'h3, 32'h0, 4'hF, 1'h1, 1'h1};
        send(hr, 1'h1, 1'h1);
        u_issue.idle();
        chk_row(hr);
        hr = '{3'h6, 32'h0, 32'hAB, 2'h0, 4'h0, 4'h1, 4'h2, 4'hD, 32'hAB, 4'hF, 1'h1, 1'h1};
        send(hr, 1'h1, 1'h1);
        u_issue.idle();
        chk_row(hr);
        // Reset in mid-run must also clear the sticky flag
        nrst = 1'h0;
        #1;
        chk_quiet(32'h0, 4'h0);
        cmp1(sticky_saturation_flag_r, 1'h0);
        @(posedge ref_clk);
        #1;
        nrst = 1'h1;
        // A clamping saturate that fails its condition must not set the sticky flag
        send(rows[15], 1'h1, 1'h0);
        u_issue.idle();
        cmp1(sticky_saturation_flag_r, 1'h0);
        chk_quiet(32'h0, 4'h0);
        hr = '{3'h0, 32'h00030005, 32'h0, 2'h0, 4'h4, 4'h1, 4'h2, 4'h3,
               32'h00030005, 4'h0, 1'h0, 1'h0};
        send(hr, 1'h1, 1'h1);
        u_issue.idle();
        chk_row(hr);
        final_report();
    end
endmodule // tb_top
